//--- logic/sle_defs.svh
`ifndef SLE_DEFS_SVH
`define SLE_DEFS_SVH

// ----------------------------------------------------------------
// Timing, in the units printed, and the clock rate.
// ----------------------------------------------------------------
`define SLE_CLK_KHZ 25000
`define SLE_ACK_US 5000
`define SLE_GUARD_US 10000
`define SLE_CONN_US 5000
`define SLE_RR_REP_US 10000

// ----------------------------------------------------------------
// Window bounds, frame coding and register map.
// ----------------------------------------------------------------
`define SLE_WIN_DEF 3'h4
`define SLE_WIN_MIN 3'h2
`define SLE_CTRL_RSET 8'hF9
`define SLE_CTRL_UA 8'hE6
`define SLE_I_TAG 2'h2
`define SLE_S_TAG 3'h6
`define SLE_S_RR 2'h0
`define SLE_S_REJ 2'h1
`define SLE_S_RNR 2'h2
`define SLE_S_SREJ 2'h3
`define SLE_CAP_SREJ 0
`define SLE_A_CFG 2'h0
`define SLE_A_STAT 2'h1
`define SLE_A_SEQ 2'h2
`define SLE_CFG_START 5
`define SLE_CFG_BUSY 4
`define SLE_CFG_SREJ 3

`endif

//--- logic/sle_pkg.sv
`default_nettype none
package sle_pkg;
	typedef enum logic [1:0] {
		SLE_DOWN = 2'b00,
		SLE_SEND = 2'b01,
		SLE_WAIT = 2'b11,
		SLE_UP = 2'b10
	} sle_state_t;
	typedef struct packed {
		logic [7:0] ctrl;
		logic hasWin;
		logic [7:0] win;
		logic hasCap;
		logic [7:0] cap;
	} sle_frame_t;
endpackage
`default_nettype wire

//--- logic/sle_link_endpoint.sv
// The implementer's own choices: strobed register access and the register offsets.
`default_nettype none
`include "sle_defs.svh"
// What this block does
// - Agreed window fixed until next reset
// - Too-large offer answered by smaller reset
// - Window in reset frames is 2 to 4, or the peer's offer echoed when not above ours
// - Adopt smaller requested window, send acknowledge
// - Unsupported capability: reply flagging supported only
// - Reply window never above peer's offer
// - Identical offer gets acknowledge, not reset
// - Reset frame layout and empty acknowledge
// - Capability bit zero is selective reject
// - Default window four, reduced only at setup
// - Acknowledge received frames within bounded time
// - Retransmit unacknowledged frames after guard time
// - Retry setup when no reply in time
// - Three modulo-8 counters, send counts up
// - Modulo-8 window test
// - Counters cleared after link establishment
// - Reset starts link, discards buffers, notifies
// - Target acknowledges, initiator then established
// - Before setup discard all but resets
// - Acknowledge timer stopped by piggybacked frames
// - Gap in sequence sends reject
// - Not-ready pauses peer, ready repeated
// - Selective reject only when negotiated
// - One selective reject outstanding at once
// - Single loss: selective reject and buffer
module sle_link_endpoint #(
	parameter int unsigned CW = 24,
	parameter int unsigned ACK_TIME_LIMIT_CYC =
		`SLE_ACK_US * `SLE_CLK_KHZ / 1000,
	parameter int unsigned GUARD_RETRANSMIT_TIME_CYC =
		(`SLE_GUARD_US * `SLE_CLK_KHZ + 999) / 1000,
	parameter int unsigned CONNECTION_TIME_LIMIT_CYC =
		`SLE_CONN_US * `SLE_CLK_KHZ / 1000,
	parameter int unsigned RR_REPEAT_CYC =
		`SLE_RR_REP_US * `SLE_CLK_KHZ / 1000,
	parameter logic SREJ_DEF = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// Frames from the framer
	input wire logic rxValid,
	input wire sle_pkg::sle_frame_t rxFrame,
	// Frames to the framer
	output logic txValid,
	output sle_pkg::sle_frame_t txFrame,
	input wire logic txReady,
	// Upper layer
	input wire logic sendReq,
	output logic sendTaken,
	output logic [2:0] sendSeq,
	output logic rxDeliver,
	output logic [2:0] rxSeq,
	output logic linkUp,
	output logic linkReset
);
	import sle_pkg::*;

	function automatic logic inWin(input logic [2:0] x, input logic [2:0] y,
		input logic [2:0] z);
		if (x <= z)
			return (x <= y) && (y < z);
		return (y >= x) || (y < z);
	endfunction

	// ----------------------------------------------------------------
	// State and decode
	// ----------------------------------------------------------------
	sle_state_t state_q;
	sle_frame_t txFrame_q, txNext;
	logic [2:0] cfgWin_q, win_q, propWin_q, ns_q, vr_q, dn_q;
	logic [2:0] bufSeq_q, resendSeq_q, seqOut, rxSeq_q, sendSeq_q;
	logic [7:0] propCap_q, offWin, offCap, regRdData_q;
	logic cfgSrej_q, cfgBusy_q, srejNeg_q, txValid_q;
	logic pendRset_q, pendUa_q, pendRej_q, pendSrej_q, pendAck_q;
	logic ldRset, ldUa, ldRej, ldSrej, ldAck, ldI;
	logic rejOut_q, srejOut_q, bufValid_q, peerBusy_q, resend_q;
	logic ackRun_q, rrRep_q, busySent_q, drainPend_q;
	logic sendTaken_q, rxDeliver_q, linkUp_q, linkReset_q;
	logic [CW-1:0] ackCnt_q, grdCnt_q, conCnt_q, rrCnt_q, t1Lim;
	logic isUp, rxI, rxS, rxRset, rxUa, tooBig, capBad, estab;
	logic rsetReply, startReq, ackOk, takeI, gapI, useSrej, drain;
	logic txFree, sentRset, t1Exp, t2Exp, t3Exp, trrExp, canSend;
	logic busyEdge, resumeEdge, rewind;
	logic [1:0] sType;
	logic [2:0] rxNs, rxNr;

	assign isUp = state_q == SLE_UP;
	assign rxNs = rxFrame.ctrl[5:3];
	assign rxNr = rxFrame.ctrl[2:0];
	assign sType = rxFrame.ctrl[4:3];
	assign rxI = rxValid && rxFrame.ctrl[7:6] == `SLE_I_TAG;
	assign rxS = rxValid && rxFrame.ctrl[7:5] == `SLE_S_TAG;
	assign rxRset = rxValid && rxFrame.ctrl == `SLE_CTRL_RSET;
	assign rxUa = rxValid && rxFrame.ctrl == `SLE_CTRL_UA;
	assign offWin = rxFrame.hasWin ? rxFrame.win : {5'h0, `SLE_WIN_DEF};
	assign offCap = rxFrame.hasCap ? rxFrame.cap : 8'h00;
	assign tooBig = offWin > {5'h0, cfgWin_q};
	assign capBad = offCap[`SLE_CAP_SREJ] && !cfgSrej_q;
	assign rsetReply = rxRset && (tooBig || capBad);
	assign estab = (rxRset && !rsetReply) || (rxUa && state_q == SLE_WAIT);
	assign startReq = regWr && regAddr == `SLE_A_CFG &&
		regWrData[`SLE_CFG_START];
	// sequenced frames only count once the link is up
	assign ackOk = isUp && (rxI || rxS) &&
		inWin(dn_q, rxNr, 3'(ns_q + 3'h1));
	assign takeI = isUp && rxI && !cfgBusy_q && rxNs == vr_q;
	assign gapI = isUp && rxI && !cfgBusy_q && rxNs != vr_q &&
		inWin(vr_q, rxNs, 3'(vr_q + win_q));
	// selective reject for a single loss
	assign useSrej = gapI && srejNeg_q && rxNs == 3'(vr_q + 3'h1) &&
		!srejOut_q && !bufValid_q;
	assign drain = takeI && bufValid_q && bufSeq_q == 3'(vr_q + 3'h1);
	assign rewind = isUp && rxS && sType == `SLE_S_REJ && ackOk;
	assign busyEdge = isUp && cfgBusy_q && !busySent_q;
	assign resumeEdge = isUp && !cfgBusy_q && busySent_q;
	assign txFree = !txValid_q || txReady;
	assign sentRset = txValid_q && txReady &&
		txFrame_q.ctrl == `SLE_CTRL_RSET;
	assign seqOut = resend_q ? resendSeq_q : ns_q;
	assign canSend = isUp && sendReq && !peerBusy_q &&
		(resend_q || inWin(dn_q, ns_q, 3'(dn_q + win_q)));

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			cfgWin_q <= `SLE_WIN_DEF;
			cfgSrej_q <= SREJ_DEF;
			cfgBusy_q <= 1'b0;
		end else if (regWr && regAddr == `SLE_A_CFG) begin
			// local window clamped to 2 to 4
			if (regWrData[2:0] < `SLE_WIN_MIN)
				cfgWin_q <= `SLE_WIN_MIN;
			else if (regWrData[2:0] > `SLE_WIN_DEF)
				cfgWin_q <= `SLE_WIN_DEF;
			else
				cfgWin_q <= regWrData[2:0];
			cfgSrej_q <= regWrData[`SLE_CFG_SREJ];
			cfgBusy_q <= regWrData[`SLE_CFG_BUSY];
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			regRdData_q <= 8'h00;
		else if (regRd) begin
			case (regAddr)
				`SLE_A_CFG:
					regRdData_q <= {3'h0, cfgBusy_q, cfgSrej_q, cfgWin_q};
				`SLE_A_STAT:
					regRdData_q <= {2'h0, state_q, srejNeg_q, win_q};
				`SLE_A_SEQ:
					regRdData_q <= {1'b0, dn_q, 1'b0, ns_q};
				default:
					regRdData_q <= {5'h0, vr_q};
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Transmit choice, one frame held until the framer takes it
	// ----------------------------------------------------------------
	always_comb begin
		txNext = '0;
		ldRset = 1'b0;
		ldUa = 1'b0;
		ldSrej = 1'b0;
		ldRej = 1'b0;
		ldAck = 1'b0;
		ldI = 1'b0;
		if (txFree) begin
			if (pendRset_q) begin
				ldRset = 1'b1;
				txNext.ctrl = `SLE_CTRL_RSET;
				txNext.hasWin = 1'b1;
				txNext.win = {5'h0, propWin_q};
				txNext.hasCap = 1'b1;
				txNext.cap = propCap_q;
			end else if (pendUa_q) begin
				ldUa = 1'b1;
				txNext.ctrl = `SLE_CTRL_UA;
			end else if (pendSrej_q) begin
				ldSrej = 1'b1;
				txNext.ctrl = {`SLE_S_TAG, `SLE_S_SREJ, vr_q};
			end else if (pendRej_q) begin
				ldRej = 1'b1;
				txNext.ctrl = {`SLE_S_TAG, `SLE_S_REJ, vr_q};
			end else if (pendAck_q) begin
				// not-ready while the upper layer is busy
				ldAck = 1'b1;
				txNext.ctrl = {`SLE_S_TAG,
					cfgBusy_q ? `SLE_S_RNR : `SLE_S_RR, vr_q};
			end else if (canSend) begin
				ldI = 1'b1;
				txNext.ctrl = {`SLE_I_TAG, seqOut, vr_q};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			txValid_q <= 1'b0;
			txFrame_q <= '0;
		end else if (txFree) begin
			txValid_q <= ldRset | ldUa | ldSrej | ldRej | ldAck | ldI;
			txFrame_q <= txNext;
		end
	end

	// Each pending flag: a new cause wins over the load that clears it.
	always_ff @(posedge clk) begin
		if (reset) begin
			pendRset_q <= 1'b0;
			pendUa_q <= 1'b0;
			pendRej_q <= 1'b0;
			pendSrej_q <= 1'b0;
			pendAck_q <= 1'b0;
		end else begin
			pendRset_q <= startReq || rsetReply ||
				(state_q == SLE_WAIT && t3Exp && !rxUa && !rxRset) ||
				(pendRset_q && !ldRset && !estab);
			pendUa_q <= (rxRset && !rsetReply) || (pendUa_q && !ldUa);
			pendRej_q <= (gapI && !useSrej && !rejOut_q) ||
				(pendRej_q && !ldRej && !estab);
			pendSrej_q <= useSrej || (pendSrej_q && !ldSrej && !estab);
			pendAck_q <= t1Exp || trrExp || busyEdge || resumeEdge ||
				(pendAck_q && !ldAck && !ldI && isUp);
		end
	end

	// ----------------------------------------------------------------
	// Link establishment
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= SLE_DOWN;
			propWin_q <= `SLE_WIN_DEF;
			propCap_q <= 8'h00;
			win_q <= `SLE_WIN_DEF;
			srejNeg_q <= 1'b0;
		end else begin
			if (startReq) begin
				propWin_q <= cfgWin_q;
				propCap_q <= {7'h00, cfgSrej_q};
			end else if (rsetReply) begin
				// reply window never above the offer
				propWin_q <= tooBig ? cfgWin_q : offWin[2:0];
				propCap_q <= {7'h00, cfgSrej_q & offCap[`SLE_CAP_SREJ]};
			end
			if (estab) begin
				win_q <= rxRset ? offWin[2:0] : propWin_q;
				srejNeg_q <= rxRset ? offCap[`SLE_CAP_SREJ] :
					propCap_q[`SLE_CAP_SREJ];
			end
			if (rxRset)
				state_q <= rsetReply ? SLE_SEND : SLE_UP;
			else begin
				case (state_q)
					SLE_DOWN:
						if (startReq)
							state_q <= SLE_SEND;
					SLE_SEND:
						if (sentRset)
							state_q <= SLE_WAIT;
					SLE_WAIT: begin
						if (rxUa)
							state_q <= SLE_UP;
						else if (t3Exp || startReq)
							state_q <= SLE_SEND;
					end
					SLE_UP:
						if (startReq)
							state_q <= SLE_SEND;
					default:
						state_q <= SLE_DOWN;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequence variables and receive buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset || estab || startReq) begin
			ns_q <= 3'h0;
			vr_q <= 3'h0;
			dn_q <= 3'h0;
			rejOut_q <= 1'b0;
			srejOut_q <= 1'b0;
			bufValid_q <= 1'b0;
			bufSeq_q <= 3'h0;
			peerBusy_q <= 1'b0;
			resend_q <= 1'b0;
			resendSeq_q <= 3'h0;
		end else begin
			if (takeI)
				vr_q <= drain ? 3'(vr_q + 3'h2) : 3'(vr_q + 3'h1);
			if (ackOk)
				dn_q <= rxNr;
			if (rewind)
				ns_q <= rxNr;
			else if (t2Exp)
				ns_q <= dn_q;
			else if (ldI && !resend_q)
				ns_q <= 3'(ns_q + 3'h1);
			if (takeI)
				rejOut_q <= 1'b0;
			else if (gapI && !useSrej)
				rejOut_q <= 1'b1;
			if (useSrej) begin
				srejOut_q <= 1'b1;
				bufValid_q <= 1'b1;
				bufSeq_q <= rxNs;
			end else if (drain) begin
				srejOut_q <= 1'b0;
				bufValid_q <= 1'b0;
			end
			if (isUp && rxS)
				peerBusy_q <= sType == `SLE_S_RNR;
			if (isUp && rxS && sType == `SLE_S_SREJ && srejNeg_q) begin
				resend_q <= 1'b1;
				resendSeq_q <= rxNr;
			end else if (ldI)
				resend_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	// limit scales with the window
	assign t1Lim = CW'(ACK_TIME_LIMIT_CYC / 4) * {{(CW-3){1'b0}}, win_q};
	assign t1Exp = ackRun_q && ackCnt_q >= t1Lim;
	assign t2Exp = isUp && grdCnt_q == CW'(GUARD_RETRANSMIT_TIME_CYC);
	assign t3Exp = conCnt_q == CW'(CONNECTION_TIME_LIMIT_CYC);
	assign trrExp = rrRep_q && rrCnt_q == CW'(RR_REPEAT_CYC);

	always_ff @(posedge clk) begin
		if (reset || !isUp) begin
			ackRun_q <= 1'b0;
			ackCnt_q <= '0;
		end else if (takeI && !ackRun_q) begin
			ackRun_q <= 1'b1;
			ackCnt_q <= '0;
		end else if (ldI || ldAck || t1Exp) begin
			// sent frames carry the acknowledge
			// Stopping at expiry keeps one expiry to one queued frame.
			ackRun_q <= 1'b0;
			ackCnt_q <= '0;
		end else if (ackRun_q && !t1Exp)
			ackCnt_q <= ackCnt_q + 1'b1;
	end

	always_ff @(posedge clk) begin
		// guard restarts on each send or acknowledge
		if (reset || !isUp || dn_q == ns_q || ldI || ackOk || t2Exp)
			grdCnt_q <= '0;
		else
			grdCnt_q <= grdCnt_q + 1'b1;
	end

	always_ff @(posedge clk) begin
		// connection time runs from the reset leaving
		if (reset || state_q != SLE_WAIT || t3Exp)
			conCnt_q <= '0;
		else
			conCnt_q <= conCnt_q + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (reset || !isUp) begin
			busySent_q <= 1'b0;
			rrRep_q <= 1'b0;
			rrCnt_q <= '0;
		end else begin
			busySent_q <= cfgBusy_q;
			// ready repeated until an I frame arrives
			if (rxI || cfgBusy_q)
				rrRep_q <= 1'b0;
			else if (resumeEdge)
				rrRep_q <= 1'b1;
			if (ldAck || !rrRep_q || trrExp)
				rrCnt_q <= '0;
			else if (!trrExp)
				rrCnt_q <= rrCnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Upper-layer outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			sendTaken_q <= 1'b0;
			sendSeq_q <= 3'h0;
			rxDeliver_q <= 1'b0;
			rxSeq_q <= 3'h0;
			drainPend_q <= 1'b0;
			linkUp_q <= 1'b0;
			linkReset_q <= 1'b0;
		end else begin
			sendTaken_q <= ldI;
			if (ldI)
				sendSeq_q <= seqOut;
			// buffered frame follows one cycle later
			rxDeliver_q <= takeI || drainPend_q;
			rxSeq_q <= takeI ? rxNs : bufSeq_q;
			drainPend_q <= drain;
			linkUp_q <= isUp;
			// upper layer told of every link reset
			linkReset_q <= estab || (startReq && isUp);
		end
	end

	assign regRdData = regRdData_q;
	assign txValid = txValid_q;
	assign txFrame = txFrame_q;
	assign sendTaken = sendTaken_q;
	assign sendSeq = sendSeq_q;
	assign rxDeliver = rxDeliver_q;
	assign rxSeq = rxSeq_q;
	assign linkUp = linkUp_q;
	assign linkReset = linkReset_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_discard;
		@(posedge clk) disable iff (reset)
		!isUp && rxI |=> !rxDeliver_q || $past(drainPend_q);
	endproperty
	a_discard: assert property (p_discard)
		else $error("frame delivered before link up");

	property p_smaller;
		@(posedge clk) disable iff (reset)
		rxRset && tooBig && !startReq |=>
			pendRset_q && {5'h0, propWin_q} < $past(offWin);
	endproperty
	a_smaller: assert property (p_smaller)
		else $error("oversized offer not answered smaller");

	property p_winrange;
		@(posedge clk) disable iff (reset)
		txValid_q && txFrame_q.ctrl == `SLE_CTRL_RSET |->
			txFrame_q.win >= {5'h0, `SLE_WIN_MIN} &&
			txFrame_q.win <= {5'h0, `SLE_WIN_DEF};
	endproperty
	a_winrange: assert property (p_winrange)
		else $error("reset frame window out of range");

	property p_clear;
		@(posedge clk) disable iff (reset)
		estab |=> ns_q == 3'h0 && vr_q == 3'h0 && dn_q == 3'h0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("counters not cleared at establishment");

	property p_nsinc;
		@(posedge clk) disable iff (reset)
		ldI && !resend_q && !rewind && !t2Exp && !estab && !startReq |=>
			ns_q == 3'($past(ns_q) + 3'h1) && sendTaken_q;
	endproperty
	a_nsinc: assert property (p_nsinc)
		else $error("send counter did not advance");

	property p_retry;
		@(posedge clk) disable iff (reset)
		state_q == SLE_WAIT && t3Exp && !rxValid && !regWr |=>
			state_q == SLE_SEND ##0 pendRset_q;
	endproperty
	a_retry: assert property (p_retry)
		else $error("no setup retry after connection time");

	property p_srejneg;
		@(posedge clk) disable iff (reset)
		txValid_q && txFrame_q.ctrl[7:3] == {`SLE_S_TAG, `SLE_S_SREJ}
			|-> srejNeg_q;
	endproperty
	a_srejneg: assert property (p_srejneg)
		else $error("selective reject without negotiation");

	property p_winfix;
		@(posedge clk) disable iff (reset)
		!estab |=> $stable(win_q);
	endproperty
	a_winfix: assert property (p_winfix)
		else $error("window changed outside establishment");

	property p_piggy;
		@(posedge clk) disable iff (reset)
		ldI && !takeI |=> !ackRun_q;
	endproperty
	a_piggy: assert property (p_piggy)
		else $error("ack timer kept running after send");
endmodule
`default_nettype wire

//--- sim/sle_peer_model.sv
`default_nettype none
`include "sle_defs.svh"
module sle_peer_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Frames from the endpoint
	input wire logic txValid,
	input wire sle_pkg::sle_frame_t txFrame,
	output logic txReady,
	// Frames to the endpoint
	output logic rxValid,
	output sle_pkg::sle_frame_t rxFrame,
	// Cycles of delay before taking a frame
	input wire logic [3:0] stall
);
	timeunit 1ns;
	timeprecision 1ps;
	import sle_pkg::*;

	sle_frame_t got[$];
	logic [3:0] cnt;

	initial begin
		txReady = 1'b0;
		rxValid = 1'b0;
		rxFrame = '0;
	end

	// ----------------------------------------------------------------
	// Frame acceptance, prompt or slow.
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			txReady <= 1'b0;
			cnt <= 4'h0;
		end else if (txValid && txReady) begin
			got.push_back(txFrame);
			txReady <= 1'b0;
			cnt <= 4'h0;
		end else if (txValid) begin
			cnt <= cnt + 4'h1;
			txReady <= (cnt >= stall);
		end
	end

	function automatic sle_frame_t rset(input logic hw, input logic [7:0] w,
		input logic hc, input logic [7:0] c);
		rset = '{`SLE_CTRL_RSET, hw, w, hc, c & 8'h01};
	endfunction

	// The line never keeps a stale frame, so an unqualified read shows up.
	task automatic send(input sle_frame_t f);
		@(posedge clk);
		rxValid <= 1'b1;
		rxFrame <= f;
		@(posedge clk);
		rxValid <= 1'b0;
		rxFrame <= ~f;
	endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
`include "sle_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sle_pkg::*;

	logic clk, reset, regWr, regRd, rxValid, txValid, txReady, sendReq;
	logic sendTaken, rxDeliver, linkUp, linkReset;
	logic [1:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [2:0] sendSeq, rxSeq;
	logic [3:0] stall;
	sle_frame_t rxFrame, txFrame, f;
	int mismatches, comparisons, deliverCount, resetCount, takenCount, n;
	localparam sle_frame_t UA = '{`SLE_CTRL_UA, 1'b0, 8'h00, 1'b0, 8'h00};

	sle_link_endpoint #(.ACK_TIME_LIMIT_CYC(40),
		.GUARD_RETRANSMIT_TIME_CYC(200), .CONNECTION_TIME_LIMIT_CYC(60),
		.RR_REPEAT_CYC(100)) i_dut (.clk(clk), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .rxValid(rxValid),
		.rxFrame(rxFrame), .txValid(txValid), .txFrame(txFrame),
		.txReady(txReady), .sendReq(sendReq), .sendTaken(sendTaken),
		.sendSeq(sendSeq), .rxDeliver(rxDeliver), .rxSeq(rxSeq),
		.linkUp(linkUp), .linkReset(linkReset));

	sle_peer_model i_peer (.clk(clk), .reset(reset), .txValid(txValid),
		.txFrame(txFrame), .txReady(txReady), .rxValid(rxValid),
		.rxFrame(rxFrame), .stall(stall));

	always #20 clk = ~clk;

	always @(posedge clk) begin
		if (rxDeliver === 1'b1)
			deliverCount++;
		if (linkReset === 1'b1)
			resetCount++;
		if (sendTaken === 1'b1)
			takenCount++;
	end

	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task automatic results;
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic regW(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic chkReg(input string what, input logic [1:0] a,
		input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(what, e, regRdData);
	endtask

	// A frame that never comes ends the run rather than hanging it.
	// Polling on the falling edge keeps clear of the model's push.
	task automatic getFrame(input int bound, input logic [7:0] e);
		n = 0;
		while (i_peer.got.size() == 0) begin
			if (n == bound) begin
				mismatches++;
				results();
			end
			@(negedge clk);
			n++;
		end
		f = i_peer.got.pop_front();
		chk("ctrl", e, f.ctrl);
	endtask

	task automatic drain(input int c);
		repeat (c) @(posedge clk);
		i_peer.got.delete();
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task automatic t_reset;
		chkReg("stat", `SLE_A_STAT, 8'h04);
		chkReg("seq", `SLE_A_SEQ, 8'h00);
		chkReg("nr", 2'h3, 8'h00);
		chk("linkUp", 8'h00, {7'h0, linkUp});
	endtask

	task automatic t_discard;
		i_peer.send('{8'h80, 1'b0, 8'h00, 1'b0, 8'h00});
		repeat (10) @(posedge clk);
		chk("frames", 8'h00, 8'(i_peer.got.size()));
		chk("delivered", 8'h00, 8'(deliverCount));
	endtask

	task automatic t_setup;
		i_peer.send(i_peer.rset(1'b0, 8'h00, 1'b0, 8'h00));
		getFrame(10, `SLE_CTRL_UA);
		chk("uaHasWin", 8'h00, {7'h0, f.hasWin});
		repeat (2) @(posedge clk);
		chk("linkUp", 8'h01, {7'h0, linkUp});
		chk("resets", 8'h01, 8'(resetCount));
		chkReg("stat", `SLE_A_STAT, 8'h24);
		chkReg("seq", `SLE_A_SEQ, 8'h00);
	endtask

	task automatic t_ackTimer;
		i_peer.send('{8'h80, 1'b0, 8'h00, 1'b0, 8'h00});
		getFrame(60, 8'hC1);
		chk("rrLate", 8'h01, 8'(n <= 48));
		chk("rrEarly", 8'h01, 8'(n >= 36));
		chk("delivered", 8'h01, 8'(deliverCount));
		chk("rxSeq", 8'h00, {5'h0, rxSeq});
	endtask

	task automatic t_reject;
		i_peer.send('{8'h90, 1'b0, 8'h00, 1'b0, 8'h00});
		getFrame(10, 8'hC9);
		chk("delivered", 8'h01, 8'(deliverCount));
		drain(120);
	endtask

	task automatic t_send;
		@(posedge clk);
		sendReq <= 1'b1;
		@(posedge clk);
		sendReq <= 1'b0;
		getFrame(10, 8'h81);
		chk("sendSeq", 8'h00, {5'h0, sendSeq});
		chk("taken", 8'h01, 8'(takenCount));
		chkReg("seq", `SLE_A_SEQ, 8'h01);
		i_peer.send('{8'hC1, 1'b0, 8'h00, 1'b0, 8'h00});
		chkReg("seq", `SLE_A_SEQ, 8'h11);
		drain(60);
	endtask

	task automatic t_caps;
		regW(`SLE_A_CFG, 8'h04);
		chkReg("stat", `SLE_A_STAT, 8'h24);
		i_peer.send(i_peer.rset(1'b1, 8'h04, 1'b1, 8'h01));
		getFrame(10, `SLE_CTRL_RSET);
		chk("win", 8'h04, f.win);
		chk("cap", 8'h00, f.cap);
		i_peer.send(UA);
		repeat (3) @(posedge clk);
		chkReg("stat", `SLE_A_STAT, 8'h24);
		chkReg("seq", `SLE_A_SEQ, 8'h00);
	endtask

	task automatic t_reduce;
		regW(`SLE_A_CFG, 8'h0A);
		i_peer.send(i_peer.rset(1'b0, 8'h00, 1'b0, 8'h00));
		getFrame(10, `SLE_CTRL_RSET);
		chk("win", 8'h02, f.win);
		i_peer.send(i_peer.rset(1'b1, 8'h02, 1'b1, 8'h01));
		getFrame(10, `SLE_CTRL_UA);
		repeat (3) @(posedge clk);
		chkReg("stat", `SLE_A_STAT, 8'h2A);
	endtask

	task automatic t_retry;
		stall <= 4'h3;
		regW(`SLE_A_CFG, 8'h0C);
		regW(`SLE_A_CFG, 8'h2C);
		getFrame(20, `SLE_CTRL_RSET);
		chk("win", 8'h04, f.win);
		getFrame(90, `SLE_CTRL_RSET);
		chk("retryTime", 8'h01, 8'(n <= 72));
		i_peer.send(UA);
		repeat (3) @(posedge clk);
		chk("linkUp", 8'h01, {7'h0, linkUp});
		chk("resets", 8'h05, 8'(resetCount));
		stall <= 4'h0;
	endtask

	task automatic t_busy;
		regW(`SLE_A_CFG, 8'h1C);
		getFrame(10, 8'hD0);
		regW(`SLE_A_CFG, 8'h0C);
		getFrame(10, 8'hC0);
		getFrame(120, 8'hC0);
		chk("rrRepeat", 8'h01, 8'(n >= 90));
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		regAddr = 2'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		sendReq = 1'b0;
		stall = 4'h0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_discard();
		t_setup();
		t_ackTimer();
		t_reject();
		t_send();
		t_caps();
		t_reduce();
		t_retry();
		t_busy();
		results();
	end
endmodule
`default_nettype wire
